// ==== verilog/thermal_alarm_output_control.v ====
// Summary of operation
// - bits [5:3] of dynamic control set Remote 2 adjustment interval.
// - interval doubles per code: 8/16 cycles at 000, up to 2048.
// - dynamic control resets to 0x40, lock-protected, soft reset restores.
// - boost bit 0 clear lets first alarm force fans to maximum; bit 0 set blocks it.
// - bits [4:2] pick first alarm window, 0.25 s doubling, 8 s cap.
// - bits [7:5] pick second alarm window, same encoding.
// - first source bit 0 enables first alarm timer, default off.
// - first alarm pin low when any enabled channel exceeds its limit.
// - second source bit 0 enables second alarm timer, default off.
// - second alarm pin low when any enabled channel exceeds limit.
// - source register bits [7:5] reserved, read as zero.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "thermal_alarm_regs.vh"
module thermal_alarm_output_control #(
  parameter MON_CYCLE = `MON_CYCLE_CLKS,
  parameter WIN_BASE  = `WIN_BASE_CLKS
) (
  input  wire        clock,              // 10 MHz clock
  input  wire        resetn,             // async reset, active low
  input  wire        psel,               // apb select
  input  wire        penable,            // apb enable
  input  wire        pwrite,             // apb direction
  input  wire [11:0] paddr,              // apb byte address
  input  wire [31:0] pwdata,             // apb write data
  input  wire [3:0]  pstrb,              // apb byte strobes
  output reg         pready,             // apb ready
  output reg  [31:0] prdata,             // apb read data
  output reg         pslverr,            // apb error
  input  wire [3:0]  first_limit_over,   // local, r1..r3 over first limit
  input  wire [3:0]  second_limit_over,  // local, r1..r3 over second limit
  output reg         first_overtemp_alarm_n,  // first alarm pin, active low
  output reg         second_overtemp_alarm_n, // second alarm pin, active low
  output reg         fan_boost_reg,      // drive all fans to maximum pwm
  output reg         remote2_decrease_pulse_reg, // decrease step allowed
  output reg         remote2_increase_pulse_reg, // increase step allowed
  output reg         loop_select_reg,    // control loop select bit
  output reg         irq                 // level interrupt
);
  reg  [7:0]  dyn_ctrl2_reg;
  reg  [7:0]  boost_win_reg;
  reg  [7:0]  alarm1_src_reg;
  reg  [7:0]  alarm2_src_reg;
  reg         lock_reg;
  reg  [2:0]  irq_status_reg;
  reg  [2:0]  irq_mask_reg;
  reg  [3:0]  over1_meta_reg;
  reg  [3:0]  over1_sync_reg;
  reg  [3:0]  over2_meta_reg;
  reg  [3:0]  over2_sync_reg;
  reg         soft_reset_reg;
  reg  [31:0] mon_tick_reg;
  reg  [11:0] mon_count_reg;
  reg         alarm1_prev_reg;
  reg         alarm2_prev_reg;
  wire [7:0]  accum1;
  wire [7:0]  accum2;
  wire        done1;
  wire        done2;
  wire        alarm1_on;
  wire        alarm2_on;
  wire        mon_step;
  wire        setup;
  wire        access;
  wire        wr;
  wire        rd;
  wire [9:0]  word;
  wire [2:0]  remote2_adjust_interval;
  wire [11:0] dec_limit;
  wire [11:0] inc_limit;
  reg  [31:0] rd_next;
  reg         err_next;
  // decodes a word index against a register index
  function hit;
    input [9:0] w;
    input [7:0] idx;
    begin
      hit = (w == {2'b00, idx});
    end
  endfunction
  assign setup  = psel && !penable;
  assign access = psel && penable && pready;
  assign wr     = access && pwrite && pstrb[0];
  assign rd     = access && !pwrite;
  assign word   = paddr[11:2];
  // two-flop synchronisers for comparator levels from the analog side
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      over1_meta_reg <= 4'h0;
      over1_sync_reg <= 4'h0;
      over2_meta_reg <= 4'h0;
      over2_sync_reg <= 4'h0;
    end else begin
      over1_meta_reg <= first_limit_over;
      over1_sync_reg <= over1_meta_reg;
      over2_meta_reg <= second_limit_over;
      over2_sync_reg <= over2_meta_reg;
    end
  end
  // any enabled channel over its own limit asserts the alarm
  assign alarm1_on = |(over1_sync_reg & alarm1_src_reg[4:1]);
  assign alarm2_on = |(over2_sync_reg & alarm2_src_reg[4:1]);
  // pins, boost and loop select all come from flops
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      first_overtemp_alarm_n  <= 1'b1;
      second_overtemp_alarm_n <= 1'b1;
      fan_boost_reg           <= 1'b0;
      loop_select_reg         <= 1'b1;
      alarm1_prev_reg         <= 1'b0;
      alarm2_prev_reg         <= 1'b0;
    end else begin
      first_overtemp_alarm_n  <= !alarm1_on;
      second_overtemp_alarm_n <= !alarm2_on;
      fan_boost_reg <= (alarm1_on && !boost_win_reg[`BW_BOOST1_BIT]) ||
                       (alarm2_on && !boost_win_reg[`BW_BOOST2_BIT]);
      loop_select_reg <= dyn_ctrl2_reg[`DYN_LOOP_SEL_BIT];
      alarm1_prev_reg <= alarm1_on;
      alarm2_prev_reg <= alarm2_on;
    end
  end
  // per-alarm window timers
  alarm_window_timer #(.WIN_BASE(WIN_BASE)) timer_one (
    .clock       (clock),
    .resetn      (resetn),
    .soft_clear  (soft_reset_reg),
    .enable      (alarm1_src_reg[`SRC_TIMER_EN_BIT]),
    .window_code (boost_win_reg[`BW_WIN1_LSB +: 3]),
    .asserted    (alarm1_on),
    .accum_reg   (accum1),
    .done_reg    (done1)
  );
  alarm_window_timer #(.WIN_BASE(WIN_BASE)) timer_two (
    .clock       (clock),
    .resetn      (resetn),
    .soft_clear  (soft_reset_reg),
    .enable      (alarm2_src_reg[`SRC_TIMER_EN_BIT]),
    .window_code (boost_win_reg[`BW_WIN2_LSB +: 3]),
    .asserted    (alarm2_on),
    .accum_reg   (accum2),
    .done_reg    (done2)
  );
  // remote 2 adjustment interval counted in monitoring cycles
  assign remote2_adjust_interval = dyn_ctrl2_reg[`DYN_R2_INT_LSB +: 3];
  assign dec_limit = `DEC_BASE_CYCLES << remote2_adjust_interval;
  assign inc_limit = `INC_BASE_CYCLES << remote2_adjust_interval;
  assign mon_step  = (mon_tick_reg >= MON_CYCLE - 1);
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mon_tick_reg               <= 32'h0;
      mon_count_reg              <= 12'h000;
      remote2_decrease_pulse_reg <= 1'b0;
      remote2_increase_pulse_reg <= 1'b0;
    end else if (soft_reset_reg) begin
      mon_tick_reg               <= 32'h0;
      mon_count_reg              <= 12'h000;
      remote2_decrease_pulse_reg <= 1'b0;
      remote2_increase_pulse_reg <= 1'b0;
    end else begin
      mon_tick_reg <= mon_step ? 32'h0 : mon_tick_reg + 32'h1;
      remote2_decrease_pulse_reg <= 1'b0;
      remote2_increase_pulse_reg <= 1'b0;
      if (mon_step) begin
        if (mon_count_reg + 12'h001 >= inc_limit) begin
          mon_count_reg              <= 12'h000;
          remote2_increase_pulse_reg <= 1'b1;
          remote2_decrease_pulse_reg <= 1'b1;
        end else begin
          mon_count_reg <= mon_count_reg + 12'h001;
          if (mon_count_reg + 12'h001 == dec_limit)
            remote2_decrease_pulse_reg <= 1'b1;
        end
      end
    end
  end
  // register writes, lock and software reset
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dyn_ctrl2_reg  <= `RST_DYN_CTRL2;
      boost_win_reg  <= `RST_BOOST_WIN;
      alarm1_src_reg <= `RST_ALARM_SRC;
      alarm2_src_reg <= `RST_ALARM_SRC;
      lock_reg       <= 1'b0;
      irq_mask_reg   <= 3'h0;
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= wr && hit(word, `IDX_SW_RESET) && pwdata[0];
      if (soft_reset_reg) begin
        dyn_ctrl2_reg  <= `RST_DYN_CTRL2;
        boost_win_reg  <= `RST_BOOST_WIN;
        alarm1_src_reg <= `RST_ALARM_SRC;
        alarm2_src_reg <= `RST_ALARM_SRC;
      end else if (wr) begin
        if (hit(word, `IDX_DYN_CTRL2)) begin
          if (!lock_reg) dyn_ctrl2_reg <= pwdata[7:0];
        end else if (hit(word, `IDX_BOOST_WIN)) begin
          if (!lock_reg) boost_win_reg <= pwdata[7:0];
        end else if (hit(word, `IDX_ALARM1_SRC)) begin
          if (!lock_reg)
            alarm1_src_reg <= pwdata[7:0] & `SRC_WRITE_MASK;
        end else if (hit(word, `IDX_ALARM2_SRC)) begin
          if (!lock_reg)
            alarm2_src_reg <= pwdata[7:0] & `SRC_WRITE_MASK;
        end else if (hit(word, `IDX_LOCK)) begin
          if (pwdata[0]) lock_reg <= 1'b1;
        end else if (hit(word, `IDX_IRQ_MASK)) begin
          irq_mask_reg <= pwdata[2:0];
        end
      end
    end
  end
  // sticky events; a new event beats the read-clear
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_status_reg <= 3'h0;
      irq            <= 1'b0;
    end else begin
      irq_status_reg <= (rd && hit(word, `IDX_IRQ_STATUS)
                         ? 3'h0 : irq_status_reg) |
                        {remote2_increase_pulse_reg,
                         alarm2_on && !alarm2_prev_reg,
                         alarm1_on && !alarm1_prev_reg};
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end
  // read mux and error for unmapped words
  always @* begin
    rd_next  = 32'h0;
    err_next = 1'b0;
    if (hit(word, `IDX_DYN_CTRL2))
      rd_next = {24'h0, dyn_ctrl2_reg};
    else if (hit(word, `IDX_BOOST_WIN))
      rd_next = {24'h0, boost_win_reg};
    else if (hit(word, `IDX_ALARM1_SRC))
      rd_next = {24'h0, alarm1_src_reg};
    else if (hit(word, `IDX_ALARM2_SRC))
      rd_next = {24'h0, alarm2_src_reg};
    else if (hit(word, `IDX_LOCK))
      rd_next = {31'h0, lock_reg};
    else if (hit(word, `IDX_SW_RESET))
      rd_next = 32'h0;
    else if (hit(word, `IDX_IRQ_STATUS))
      rd_next = {29'h0, irq_status_reg};
    else if (hit(word, `IDX_IRQ_MASK))
      rd_next = {29'h0, irq_mask_reg};
    else if (hit(word, `IDX_ALARM1_ACCUM))
      rd_next = {24'h0, accum1};
    else if (hit(word, `IDX_ALARM2_ACCUM))
      rd_next = {24'h0, accum2};
    else
      err_next = 1'b1;
  end
  // apb slave: no wait states, answer in the cycle after setup
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && err_next;
      prdata  <= (setup && !pwrite) ? rd_next : 32'h0;
    end
  end
  // done pulses are unused beyond the accumulators
  wire unused_done;
  assign unused_done = done1 | done2;
endmodule // thermal_alarm_output_control
`default_nettype wire

// ==== verilog/thermal_alarm_regs.vh ====
`ifndef THERMAL_ALARM_REGS_VH
`define THERMAL_ALARM_REGS_VH
// register word indexes (printed offsets are indexes; address = 4 * index)
`define IDX_DYN_CTRL2        8'h0c
`define IDX_BOOST_WIN        8'h0d
`define IDX_ALARM1_SRC       8'h0e
`define IDX_ALARM2_SRC       8'h0f
`define IDX_LOCK             8'h20
`define IDX_SW_RESET         8'h21
`define IDX_IRQ_STATUS       8'h22
`define IDX_IRQ_MASK         8'h23
`define IDX_ALARM1_ACCUM     8'h24
`define IDX_ALARM2_ACCUM     8'h25
// reset values
`define RST_DYN_CTRL2        8'h40
`define RST_BOOST_WIN        8'h00
`define RST_ALARM_SRC        8'h00
// field positions
`define DYN_R2_INT_LSB       3
`define DYN_LOOP_SEL_BIT     6
`define BW_BOOST1_BIT        0
`define BW_BOOST2_BIT        1
`define BW_WIN1_LSB          2
`define BW_WIN2_LSB          5
`define SRC_TIMER_EN_BIT     0
`define SRC_CHAN_LSB         1
`define SRC_WRITE_MASK       8'h1f
// interrupt status bits
`define IRQ_ALARM1_BIT       0
`define IRQ_ALARM2_BIT       1
`define IRQ_ADJ_BIT          2
// timing: one monitoring cycle is 125 ms; windows double from a 0.25 s base
`define CLOCK_HZ             10000000
`define MON_CYCLE_MS         125
`define WIN_BASE_MS          250
`define MON_CYCLE_CLKS       (`CLOCK_HZ / 1000 * `MON_CYCLE_MS)
`define WIN_BASE_CLKS        (`CLOCK_HZ / 1000 * `WIN_BASE_MS)
`define DEC_BASE_CYCLES      12'h008
`define INC_BASE_CYCLES      12'h010
`define WIN_MAX_CODE         3'h5
`endif

// ==== verilog/alarm_window_timer.v ====
`timescale 1ns/1ps
`default_nettype none
`include "thermal_alarm_regs.vh"
// measures asserted time of one alarm within a repeating window
module alarm_window_timer #(
  parameter WIN_BASE = `WIN_BASE_CLKS
) (
  input  wire        clock,        // system clock
  input  wire        resetn,       // async reset, active low
  input  wire        soft_clear,   // software reset pulse
  input  wire        enable,       // timer enable
  input  wire [2:0]  window_code,  // window select
  input  wire        asserted,     // alarm currently active
  output reg  [7:0]  accum_reg,    // last window's active time, 1/256 units
  output reg         done_reg      // one-cycle pulse at each window end
);
  reg  [31:0] tick_reg;
  reg  [31:0] active_reg;
  reg  [31:0] win_len;
  wire [2:0]  eff_code;
  wire [31:0] act_sum;
  wire [39:0] frac;
  // widened so the scaled count cannot overflow at long windows
  assign act_sum = active_reg + {31'h0, asserted};
  assign frac    = {act_sum, 8'h00} / {8'h00, win_len};
  // codes above 101 saturate at 8 s
  assign eff_code = (window_code > `WIN_MAX_CODE) ? `WIN_MAX_CODE
                                                  : window_code;
  always @* begin
    win_len = WIN_BASE << eff_code;
  end
  // window counter restarts measurement at each window start
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_reg   <= 32'h0;
      active_reg <= 32'h0;
      accum_reg  <= 8'h00;
      done_reg   <= 1'b0;
    end else if (soft_clear || !enable) begin
      tick_reg   <= 32'h0;
      active_reg <= 32'h0;
      done_reg   <= 1'b0;
      if (soft_clear) accum_reg <= 8'h00;
    end else if (tick_reg >= win_len - 32'h1) begin
      tick_reg   <= 32'h0;
      active_reg <= 32'h0;
      done_reg   <= 1'b1;
      accum_reg  <= (act_sum >= win_len) ? 8'hff : frac[7:0];
    end else begin
      tick_reg   <= tick_reg + 32'h1;
      active_reg <= active_reg + {31'h0, asserted};
      done_reg   <= 1'b0;
    end
  end
endmodule // alarm_window_timer
`default_nettype wire

// ==== testbench/alarm_ctrl_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module alarm_ctrl_monitor (
  input wire logic        clock,                      // clock
  input wire logic        resetn,                     // reset, active low
  input wire logic        psel,                       // apb select
  input wire logic        penable,                    // apb enable
  input wire logic        pwrite,                     // apb direction
  input wire logic [11:0] paddr,                      // apb address
  input wire logic [31:0] pwdata,                     // apb write data
  input wire logic [3:0]  pstrb,                      // apb strobes
  input wire logic        pready,                     // apb ready
  input wire logic [31:0] prdata,                     // apb read data
  input wire logic        pslverr,                    // apb error
  input wire logic [3:0]  first_limit_over,           // channel levels
  input wire logic [3:0]  second_limit_over,          // channel levels
  input wire logic        first_overtemp_alarm_n,     // first pin
  input wire logic        second_overtemp_alarm_n,    // second pin
  input wire logic        fan_boost_reg,              // fans to maximum
  input wire logic        remote2_decrease_pulse_reg, // decrease step
  input wire logic        remote2_increase_pulse_reg, // increase step
  input wire logic        loop_select_reg,            // loop select
  input wire logic        irq                         // interrupt
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // bus answer timing and idle data
  property p_ready; psel && !penable |=> pready; endproperty
  property p_once; pready |=> !pready; endproperty
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  property p_err; pslverr |-> pready && psel && penable; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_once: assert property (p_once) else $error("ready held too long");
  a_idle: assert property (p_idle) else $error("read data outside answer");
  a_err: assert property (p_err) else $error("error outside access");
  // reserved source bits and alarm causes
  property p_rsv;
    pready && !pwrite && paddr[11:3] == 9'h007 |-> prdata[7:5] == 3'h0;
  endproperty
  property p_al1; !first_overtemp_alarm_n |-> $past(first_limit_over, 3) != 4'h0;
  endproperty
  property p_al2;
    !second_overtemp_alarm_n |-> $past(second_limit_over, 3) != 4'h0;
  endproperty
  property p_boost;
    fan_boost_reg |-> !first_overtemp_alarm_n || !second_overtemp_alarm_n
      || !$past(first_overtemp_alarm_n) || !$past(second_overtemp_alarm_n);
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved source bits read nonzero");
  a_al1: assert property (p_al1)
    else $error("first alarm low without cause");
  a_al2: assert property (p_al2)
    else $error("second alarm low without cause");
  a_boost: assert property (p_boost)
    else $error("boost without an alarm");
  // adjustment pulses
  property p_inc; remote2_increase_pulse_reg |-> remote2_decrease_pulse_reg;
  endproperty
  property p_gap;
    remote2_decrease_pulse_reg |=> !remote2_decrease_pulse_reg [*8];
  endproperty
  a_inc: assert property (p_inc)
    else $error("increase without decrease");
  a_gap: assert property (p_gap)
    else $error("adjust steps too close");
  c_alarm: cover property (!first_overtemp_alarm_n);
  c_boost: cover property (fan_boost_reg);
  c_inc: cover property (remote2_increase_pulse_reg);
  c_err: cover property (pslverr);
endmodule // alarm_ctrl_monitor
`default_nettype wire

// ==== testbench/overtemp_env_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module overtemp_env_model (
  input  wire logic       clock,             // clock
  input  wire logic       slow,              // one extra cycle of lag
  input  wire logic [3:0] first_req,         // wanted first levels
  input  wire logic [3:0] second_req,        // wanted second levels
  output var  logic [3:0] first_limit_over,  // to block
  output var  logic [3:0] second_limit_over  // to block
);
  logic [7:0] lag_reg;
  // limit comparators settle promptly or one cycle late
  always @(posedge clock) begin
    lag_reg <= {first_req, second_req};
    {first_limit_over, second_limit_over} <=
      slow ? lag_reg : {first_req, second_req};
  end
endmodule // overtemp_env_model
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int MON = 4;
  localparam int WB  = 8;
  logic        clock, resetn, psel, penable, pwrite, slow, pready, pslverr;
  logic        first_overtemp_alarm_n, second_overtemp_alarm_n, irq, a, b;
  logic        fan_boost_reg, loop_select_reg, x1, x2;
  logic        remote2_decrease_pulse_reg, remote2_increase_pulse_reg;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, v;
  logic [31:0] seed = 32'h79a0b263;
  logic [3:0]  pstrb, req1, req2;
  logic        e;
  wire  [3:0]  first_limit_over, second_limit_over;
  int          mismatches, compares, cycles, n;
  thermal_alarm_output_control #(.MON_CYCLE(MON), .WIN_BASE(WB)) dut_u (
    .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .first_limit_over, .second_limit_over,
    .first_overtemp_alarm_n, .second_overtemp_alarm_n, .fan_boost_reg,
    .remote2_decrease_pulse_reg, .remote2_increase_pulse_reg,
    .loop_select_reg, .irq);
  overtemp_env_model env_u (.clock, .slow, .first_req(req1),
    .second_req(req2), .first_limit_over, .second_limit_over);
  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 100000) begin
      mismatches++;
      end_of_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic alarm_exp(input logic [7:0] s, input logic [3:0] o);
    return !(|(s[4:1] & o));
  endfunction
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      mismatches++;
      $display("Error at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // one apb transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, d};
    pstrb <= {3'b000, w};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [7:0] want);
    apb(1'b0, ad, 8'h00);
    chk(r, {24'h0, want});
  endtask
  task automatic wait_pulse(input logic inc);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while ((inc ? remote2_increase_pulse_reg : remote2_decrease_pulse_reg)
               !== 1'b1 && n < 9000);
  endtask
  // main sequence
  initial begin
    {psel, penable, pwrite, slow, resetn} = 5'h0;
    {paddr, pwdata, pstrb, req1, req2} = '0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd(12'h030, 8'h40);
    rd(12'h034, 8'h00);
    rd(12'h038, 8'h00);
    rd(12'h03c, 8'h00);
    chk(loop_select_reg, 1'b1);
    apb(1'b0, 12'h040, 8'h00);
    chk(e, 1'b1);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      wr(12'h034, v[7:0]);
      rd(12'h034, v[7:0]);
      wr(12'h038, v[15:8]);
      rd(12'h038, v[15:8] & 8'h1f);
      wr(12'h03c, v[23:16]);
      rd(12'h03c, v[23:16] & 8'h1f);
      wr(12'h030, (v[7:0] & 8'h78) | 8'h38);
      rd(12'h030, (v[7:0] & 8'h78) | 8'h38);
      chk(loop_select_reg, v[6]);
    end
    for (int i = 0; i < 16; i++) begin
      v = (i == 0) ? 32'hfffffcff : rnd();
      wr(12'h038, {3'h0, v[3:0], 1'b0});
      wr(12'h03c, {3'h0, v[7:4], 1'b0});
      wr(12'h034, {6'h0, v[9:8]});
      req1 <= v[19:16];
      req2 <= v[23:20];
      slow <= v[24];
      repeat (8) @(posedge clock);
      x1 = alarm_exp({3'h0, v[3:0], 1'b0}, v[19:16]);
      x2 = alarm_exp({3'h0, v[7:4], 1'b0}, v[23:20]);
      chk(first_overtemp_alarm_n, x1);
      chk(second_overtemp_alarm_n, x2);
      chk(fan_boost_reg, (!x1 & !v[8]) | (!x2 & !v[9]));
    end
    // alarm event raises a status bit, mask gates the level
    wr(12'h038, 8'h02);
    req1 <= 4'h1;
    repeat (8) @(posedge clock);
    req1 <= 4'h0;
    repeat (8) @(posedge clock);
    wr(12'h08c, 8'h01);
    repeat (2) @(posedge clock);
    a = irq;
    wr(12'h08c, 8'h00);
    repeat (2) @(posedge clock);
    b = irq;
    chk(a ^ b, 1'b1);
    apb(1'b0, 12'h088, 8'h00);
    chk(r[0], 1'b1);
    apb(1'b0, 12'h088, 8'h00);
    chk(r[0], 1'b0);
    wr(12'h08c, 8'h01);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    // window timers: full assertion saturates, idle reads zero
    wr(12'h038, 8'h03);
    wr(12'h03c, 8'h01);
    req1 <= 4'h1;
    wr(12'h034, 8'h60);
    repeat (3 * WB * 8) @(posedge clock);
    rd(12'h090, 8'hff);
    rd(12'h094, 8'h00);
    wr(12'h034, 8'h1c);
    repeat (3 * WB * 32 + 8) @(posedge clock);
    rd(12'h090, 8'hff);
    // soft reset, lock, then a mid-run hard reset
    wr(12'h084, 8'h01);
    rd(12'h030, 8'h40);
    rd(12'h034, 8'h00);
    wr(12'h080, 8'h01);
    wr(12'h030, 8'h08);
    rd(12'h030, 8'h40);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    wr(12'h030, 8'h08);
    rd(12'h030, 8'h08);
    // every interval code, rising so the count never overshoots
    for (int c = 0; c < 8; c++) begin
      wr(12'h030, {2'b01, c[2:0], 3'b000});
      wait_pulse(1'b1);
      wait_pulse(1'b0);
      chk(n, (8 << c) * MON);
      wait_pulse(1'b1);
      chk(n, (8 << c) * MON);
    end
    end_of_test();
  end
endmodule // testbench
bind thermal_alarm_output_control alarm_ctrl_monitor mon_u (
  .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .pready, .prdata, .pslverr, .first_limit_over, .second_limit_over,
  .first_overtemp_alarm_n, .second_overtemp_alarm_n, .fan_boost_reg,
  .remote2_decrease_pulse_reg, .remote2_increase_pulse_reg,
  .loop_select_reg, .irq);
`default_nettype wire
